// >>> power_budget_pkg.sv
// constants and carrier types for the power budget capability registers
package power_budget_pkg;
  // ==========================================================
  // register offsets (byte addresses in config space)
  localparam logic [11:0] HEADER_OFFSET = 12'h20c;
  localparam logic [11:0] INDEX_OFFSET = 12'h210;
  localparam logic [11:0] DATA_OFFSET = 12'h214;
  localparam logic [11:0] ALLOC_OFFSET = 12'h218;
  // ==========================================================
  // header fields
  localparam logic [15:0] CAP_ID = 16'h0004;
  localparam logic [3:0] CAP_VERSION = 4'h1;
  localparam logic [11:0] NEXT_UPSTREAM = 12'h230;
  localparam logic [11:0] NEXT_DOWNSTREAM = 12'h220;
  // ==========================================================
  // index values and reset values
  localparam logic [7:0] INDEX_RESET = 8'h00;
  localparam logic [7:0] INDEX_D0_MAX = 8'h00;
  localparam logic [7:0] INDEX_D0_SUSTAINED = 8'h01;
  localparam logic [7:0] BASE_POWER_RESET = 8'h04;
  localparam logic [1:0] SCALE_RESET = 2'h0;
  localparam logic [2:0] SUBSTATE_RESET = 3'h0;
  localparam logic [1:0] POWER_LEVEL_RESET = 2'h0;
  localparam logic [2:0] TYPE_MAXIMUM = 3'h7;
  localparam logic [2:0] TYPE_SUSTAINED = 3'h1;
  localparam logic [2:0] RAIL_RESET = 3'h2;
  localparam logic SYS_ALLOC_RESET = 1'b0;
  // ==========================================================
  // field positions in the data register
  localparam int BASE_LSB = 0;
  localparam int SCALE_LSB = 8;
  localparam int SUBSTATE_LSB = 10;
  localparam int LEVEL_LSB = 13;
  localparam int TYPE_LSB = 15;
  localparam int RAIL_LSB = 18;
  // ==========================================================
  // carriers
  typedef enum logic [1:0] {
    LOAD_BASE, LOAD_SCALE, LOAD_LEVEL, LOAD_ALLOC
  } load_target_type;
  typedef struct packed {
    logic valid;
    logic write;
    logic [11:0] addr;
    logic [3:0] byte_en;
    logic [31:0] wdata;
  } cfg_req_type;
  typedef struct packed {
    logic valid;
    load_target_type target;
    logic [7:0] data;
  } preload_type;
  typedef struct packed {
    logic [7:0] index_reg;
    logic [7:0] base_power_reg;
    logic [1:0] scale_reg;
    logic [1:0] device_power_level_field_reg;
    logic sys_alloc_reg;
    logic [31:0] rdata_reg;
    logic rvalid_reg;
    logic hit_reg;
  } budget_state_type;
endpackage : power_budget_pkg

// >>> power_budget_capability.sv
// power budgeting extended capability register bank for one port
`timescale 1ns/1ps
// Function
// - header id reads fixed 0004h
// - header version reads fixed 1h
// - next pointer 230h upstream, 220h downstream
// - index low byte writable, resets 00h
// - index 00h max, 01h sustained entry
// - other index values report zero budget
// - base power bits 7:0, reset 04h
// - scale bits 9:8, reset 00b
// - sub-state bits 12:10, reset 000b
// - power level bits 14:13, reset 00b
// - type bits 17:15, reset 111b
// - rail bits 20:18, reset 010b
// - system allocated bit 0, reset 0
// - base power, scale, power level and system allocated defaults replaceable by sideband preload
module power_budget_capability (
  // clock and reset
  input wire logic i_clock,
  input wire logic i_reset_n,
  // port strap
  input wire logic i_upstream_port,
  // configuration access
  input wire power_budget_pkg::cfg_req_type i_cfg_req,
  output logic [31:0] o_cfg_rdata,
  output logic o_cfg_rvalid,
  output logic o_cfg_hit,
  // sideband preload from serial bus or eeprom loader
  input wire power_budget_pkg::preload_type i_preload
);

  // ==========================================================
  // state
  power_budget_pkg::budget_state_type state_reg;
  power_budget_pkg::budget_state_type state_next;

  // assemble the header word
  function automatic logic [31:0] header_word(input logic upstream);
    logic [11:0] next_ptr;
    next_ptr = upstream ? power_budget_pkg::NEXT_UPSTREAM
                        : power_budget_pkg::NEXT_DOWNSTREAM;
    header_word = {next_ptr, power_budget_pkg::CAP_VERSION,
                   power_budget_pkg::CAP_ID};
  endfunction : header_word

  // assemble the data word for a given index
  function automatic logic [31:0] data_word(
    input logic [7:0] index,
    input logic [7:0] base,
    input logic [1:0] scale,
    input logic [1:0] level
  );
    logic [2:0] kind;
    data_word = 32'h0000_0000;
    kind = (index == power_budget_pkg::INDEX_D0_MAX)
           ? power_budget_pkg::TYPE_MAXIMUM
           : power_budget_pkg::TYPE_SUSTAINED;
    if (index == power_budget_pkg::INDEX_D0_MAX ||
        index == power_budget_pkg::INDEX_D0_SUSTAINED) begin
      data_word[power_budget_pkg::BASE_LSB +: 8] = base;
      data_word[power_budget_pkg::SCALE_LSB +: 2] = scale;
      data_word[power_budget_pkg::SUBSTATE_LSB +: 3] =
        power_budget_pkg::SUBSTATE_RESET;
      data_word[power_budget_pkg::LEVEL_LSB +: 2] = level;
      data_word[power_budget_pkg::TYPE_LSB +: 3] = kind;
      data_word[power_budget_pkg::RAIL_LSB +: 3] =
        power_budget_pkg::RAIL_RESET;
    end
  endfunction : data_word

  // ==========================================================
  // next-state logic
  always_comb begin
    state_next = state_reg;
    state_next.rvalid_reg = 1'b0;
    // sideband preload of the defaults
    if (i_preload.valid) begin
      unique case (i_preload.target)
        power_budget_pkg::LOAD_BASE: begin
          state_next.base_power_reg = i_preload.data;
        end
        power_budget_pkg::LOAD_SCALE: begin
          state_next.scale_reg = i_preload.data[1:0];
        end
        power_budget_pkg::LOAD_LEVEL: begin
          state_next.device_power_level_field_reg = i_preload.data[1:0];
        end
        power_budget_pkg::LOAD_ALLOC: begin
          state_next.sys_alloc_reg = i_preload.data[0];
        end
      endcase
    end
    // configuration access
    if (i_cfg_req.valid) begin
      state_next.rvalid_reg = !i_cfg_req.write;
      state_next.rdata_reg = 32'h0000_0000;
      state_next.hit_reg = 1'b1;
      unique case (i_cfg_req.addr)
        power_budget_pkg::HEADER_OFFSET: begin
          state_next.rdata_reg = header_word(i_upstream_port);
        end
        power_budget_pkg::INDEX_OFFSET: begin
          // only the low byte lane holds a writable field
          if (i_cfg_req.write && i_cfg_req.byte_en[0]) begin
            state_next.index_reg = i_cfg_req.wdata[7:0];
          end
          state_next.rdata_reg = {24'h00_0000, state_reg.index_reg};
        end
        power_budget_pkg::DATA_OFFSET: begin
          // data follows the live index, writes dropped
          state_next.rdata_reg = data_word(state_reg.index_reg,
            state_reg.base_power_reg, state_reg.scale_reg,
            state_reg.device_power_level_field_reg);
        end
        power_budget_pkg::ALLOC_OFFSET: begin
          state_next.rdata_reg = {31'h0000_0000,
                                  state_reg.sys_alloc_reg};
        end
        default: begin
          state_next.hit_reg = 1'b0;
        end
      endcase
      if (i_cfg_req.write) begin
        state_next.rdata_reg = state_reg.rdata_reg;
      end
    end
  end

  // ==========================================================
  // state register
  always_ff @(posedge i_clock) begin
    if (!i_reset_n) begin
      state_reg.index_reg <= power_budget_pkg::INDEX_RESET;
      state_reg.base_power_reg <= power_budget_pkg::BASE_POWER_RESET;
      state_reg.scale_reg <= power_budget_pkg::SCALE_RESET;
      state_reg.device_power_level_field_reg <=
        power_budget_pkg::POWER_LEVEL_RESET;
      state_reg.sys_alloc_reg <= power_budget_pkg::SYS_ALLOC_RESET;
      state_reg.rdata_reg <= 32'h0000_0000;
      state_reg.rvalid_reg <= 1'b0;
      state_reg.hit_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // outputs
  assign o_cfg_rdata = state_reg.rdata_reg;
  assign o_cfg_rvalid = state_reg.rvalid_reg;
  assign o_cfg_hit = state_reg.hit_reg;

  // ==========================================================
  // checks
  logic rd_header;
  logic rd_index;
  logic rd_data;
  logic rd_alloc;
  assign rd_header = i_cfg_req.valid && !i_cfg_req.write &&
                     i_cfg_req.addr == power_budget_pkg::HEADER_OFFSET;
  assign rd_index = i_cfg_req.valid && !i_cfg_req.write &&
                    i_cfg_req.addr == power_budget_pkg::INDEX_OFFSET;
  assign rd_data = i_cfg_req.valid && !i_cfg_req.write &&
                   i_cfg_req.addr == power_budget_pkg::DATA_OFFSET;
  assign rd_alloc = i_cfg_req.valid && !i_cfg_req.write &&
                    i_cfg_req.addr == power_budget_pkg::ALLOC_OFFSET;

  property p_header_id;
    @(posedge i_clock) disable iff (!i_reset_n)
    rd_header |=> o_cfg_rvalid && o_cfg_rdata[15:0] == 16'h0004;
  endproperty
  a_header_id: assert property (p_header_id)
    else $error("header id wrong");

  property p_header_version;
    @(posedge i_clock) disable iff (!i_reset_n)
    rd_header |=> o_cfg_rdata[19:16] == 4'h1;
  endproperty
  a_header_version: assert property (p_header_version)
    else $error("header version wrong");

  property p_next_pointer;
    @(posedge i_clock) disable iff (!i_reset_n)
    rd_header |=> o_cfg_rdata[31:20] ==
      ($past(i_upstream_port) ? 12'h230 : 12'h220);
  endproperty
  a_next_pointer: assert property (p_next_pointer)
    else $error("next pointer wrong");

  property p_index_write;
    @(posedge i_clock) disable iff (!i_reset_n)
    (i_cfg_req.valid && i_cfg_req.write && i_cfg_req.byte_en[0] &&
     i_cfg_req.addr == power_budget_pkg::INDEX_OFFSET) ##1 rd_index
    |=> o_cfg_rdata == {24'h00_0000, $past(i_cfg_req.wdata[7:0], 2)};
  endproperty
  a_index_write: assert property (p_index_write)
    else $error("index readback wrong");

  property p_unsupported_zero;
    @(posedge i_clock) disable iff (!i_reset_n)
    rd_data && state_reg.index_reg > 8'h01 |=> o_cfg_rdata == 32'h0;
  endproperty
  a_unsupported_zero: assert property (p_unsupported_zero)
    else $error("unsupported entry not zero");

  property p_entry_type;
    @(posedge i_clock) disable iff (!i_reset_n)
    rd_data && state_reg.index_reg == 8'h00 |=>
      o_cfg_rdata[17:15] == 3'h7 && o_cfg_rdata[20:18] == 3'h2 &&
      o_cfg_rdata[12:10] == 3'h0 && o_cfg_rdata[31:21] == 11'h0;
  endproperty
  a_entry_type: assert property (p_entry_type)
    else $error("max entry fields wrong");

  property p_reset_defaults;
    @(posedge i_clock)
    !i_reset_n |=> state_reg.base_power_reg == 8'h04 &&
      state_reg.scale_reg == 2'h0 && state_reg.index_reg == 8'h00 &&
      state_reg.device_power_level_field_reg == 2'h0 &&
      !state_reg.sys_alloc_reg;
  endproperty
  a_reset_defaults: assert property (p_reset_defaults)
    else $error("reset defaults wrong");

  property p_preload_base;
    @(posedge i_clock) disable iff (!i_reset_n)
    i_preload.valid && i_preload.target == power_budget_pkg::LOAD_BASE
    ##1 (rd_data && state_reg.index_reg == 8'h00 && !i_preload.valid)
    |=> o_cfg_rdata[7:0] == $past(i_preload.data, 2);
  endproperty
  a_preload_base: assert property (p_preload_base)
    else $error("preloaded base power not shown");

  property p_alloc_read;
    @(posedge i_clock) disable iff (!i_reset_n)
    rd_alloc |=> o_cfg_rdata == {31'h0, $past(state_reg.sys_alloc_reg)};
  endproperty
  a_alloc_read: assert property (p_alloc_read)
    else $error("allocation register wrong");

  property p_ro_write;
    @(posedge i_clock) disable iff (!i_reset_n)
    i_cfg_req.valid && i_cfg_req.write && !i_preload.valid &&
    i_cfg_req.addr != power_budget_pkg::INDEX_OFFSET
    |=> $stable(state_reg.index_reg) && $stable(state_reg.base_power_reg);
  endproperty
  a_ro_write: assert property (p_ro_write)
    else $error("read-only write took effect");

  property p_sustained_entry;
    @(posedge i_clock) disable iff (!i_reset_n)
    rd_data && state_reg.index_reg == 8'h01 |=>
      o_cfg_rdata[17:15] == 3'h1 && o_cfg_rdata[20:18] == 3'h2 &&
      o_cfg_rdata[31:21] == 11'h0;
  endproperty
  a_sustained_entry: assert property (p_sustained_entry)
    else $error("sustained entry fields wrong");

  property p_unmapped_read;
    @(posedge i_clock) disable iff (!i_reset_n)
    i_cfg_req.valid && !i_cfg_req.write && !rd_header && !rd_index &&
    !rd_data && !rd_alloc |=> !o_cfg_hit && o_cfg_rdata == 32'h0;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read)
    else $error("unmapped read not empty");

  property p_index_hold;
    @(posedge i_clock) disable iff (!i_reset_n)
    i_cfg_req.valid && i_cfg_req.write && !i_cfg_req.byte_en[0] &&
    i_cfg_req.addr == power_budget_pkg::INDEX_OFFSET
    |=> $stable(state_reg.index_reg);
  endproperty
  a_index_hold: assert property (p_index_hold)
    else $error("index changed without lane 0");

  property p_write_no_answer;
    @(posedge i_clock) disable iff (!i_reset_n)
    i_cfg_req.valid && i_cfg_req.write |=> !o_cfg_rvalid;
  endproperty
  a_write_no_answer: assert property (p_write_no_answer)
    else $error("write produced read strobe");

  property p_preload_alloc;
    @(posedge i_clock) disable iff (!i_reset_n)
    i_preload.valid && i_preload.target == power_budget_pkg::LOAD_ALLOC
    |=> state_reg.sys_alloc_reg == $past(i_preload.data[0]);
  endproperty
  a_preload_alloc: assert property (p_preload_alloc)
    else $error("preloaded allocation flag lost");

  // main scenarios
  c_read_sustained: cover property (@(posedge i_clock)
    rd_data && state_reg.index_reg == 8'h01);
  c_read_unsupported: cover property (@(posedge i_clock)
    rd_data && state_reg.index_reg == 8'h05);
  c_preload_alloc: cover property (@(posedge i_clock)
    i_preload.valid && i_preload.target == power_budget_pkg::LOAD_ALLOC);
  c_preload_with_cfg: cover property (@(posedge i_clock)
    i_preload.valid && i_cfg_req.valid);
  c_reset_release: cover property (@(posedge i_clock)
    $rose(i_reset_n));

endmodule : power_budget_capability

// >>> power_budget_capability_tb_top.sv
// self-checking testbench for the power budget capability registers
`timescale 1ns/1ps
module power_budget_capability_tb_top;
  // ==========================================================
  // clock, reset and stimulus signals
  logic i_clock;
  logic i_reset_n;
  logic i_upstream_port;
  power_budget_pkg::cfg_req_type i_cfg_req;
  power_budget_pkg::preload_type i_preload;
  logic [31:0] o_cfg_rdata;
  logic o_cfg_rvalid;
  logic o_cfg_hit;
  int n_errors;
  int samples_checked;
  int cycle_count = 0;

  // ==========================================================
  // device under test
  power_budget_capability dut (
    .i_clock(i_clock),
    .i_reset_n(i_reset_n),
    .i_upstream_port(i_upstream_port),
    .i_cfg_req(i_cfg_req),
    .o_cfg_rdata(o_cfg_rdata),
    .o_cfg_rvalid(o_cfg_rvalid),
    .o_cfg_hit(o_cfg_hit),
    .i_preload(i_preload)
  );

  // free-running 100 MHz clock
  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  // ==========================================================
  // helpers
  task automatic give_verdict();
    $display("errors %0d checks %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // hang guard, far above the roughly one hundred cycles needed
  always @(posedge i_clock) begin
    cycle_count <= cycle_count + 1;
    if (cycle_count == 3000) begin
      n_errors = n_errors + 1;
      give_verdict();
    end
  end

  // compare one 32-bit value
  task automatic check32(input logic [31:0] got, input logic [31:0] exp);
    samples_checked = samples_checked + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check32

  // expected budget data word
  function automatic logic [31:0] word(input logic [2:0] typ,
    input logic [7:0] b, input logic [1:0] s, input logic [1:0] l);
    return {11'h000, power_budget_pkg::RAIL_RESET, typ, l,
      power_budget_pkg::SUBSTATE_RESET, s, b};
  endfunction : word

  // one-cycle access, returns in the answer cycle
  task automatic cfg(input logic wr, input logic [11:0] a,
    input logic [3:0] be, input logic [31:0] d);
    @(negedge i_clock);
    i_cfg_req = '{valid: 1'b1, write: wr, addr: a, byte_en: be, wdata: d};
    @(negedge i_clock);
    i_cfg_req.valid = 1'b0;
  endtask : cfg

  // read and judge data, strobe and hit
  task automatic rd(input logic [11:0] a, input logic [31:0] exp,
    input logic hit);
    cfg(1'b0, a, 4'h0, 32'h0000_0000);
    check32({31'h0, o_cfg_rvalid}, 32'h0000_0001);
    check32(o_cfg_rdata, exp);
    check32({31'h0, o_cfg_hit}, {31'h0, hit});
  endtask : rd

  // sideband preload strobe
  task automatic load(input power_budget_pkg::load_target_type t,
    input logic [7:0] d);
    @(negedge i_clock);
    i_preload = '{valid: 1'b1, target: t, data: d};
    @(negedge i_clock);
    i_preload.valid = 1'b0;
  endtask : load

  // ==========================================================
  // scenarios
  task automatic test_reset_values();
    i_upstream_port = 1'b1;
    rd(12'h20c, 32'h2301_0004, 1'b1);
    i_upstream_port = 1'b0;
    rd(12'h20c, 32'h2201_0004, 1'b1);
    rd(12'h210, 32'h0000_0000, 1'b1);
    rd(12'h214, 32'h000b_8004, 1'b1);
    rd(12'h218, 32'h0000_0000, 1'b1);
  endtask : test_reset_values

  task automatic test_index_select();
    cfg(1'b1, 12'h210, 4'hf, 32'hffff_ff01);
    rd(12'h210, 32'h0000_0001, 1'b1);
    rd(12'h214, word(3'h1, 8'h04, 2'h0, 2'h0), 1'b1);
    cfg(1'b1, 12'h210, 4'h0, 32'h0000_0000);
    rd(12'h210, 32'h0000_0001, 1'b1);
    cfg(1'b1, 12'h210, 4'h1, 32'h0000_0002);
    rd(12'h214, 32'h0000_0000, 1'b1);
    cfg(1'b1, 12'h210, 4'h1, 32'h0000_00ff);
    rd(12'h214, 32'h0000_0000, 1'b1);
    cfg(1'b1, 12'h210, 4'h1, 32'h0000_0000);
    rd(12'h214, word(3'h7, 8'h04, 2'h0, 2'h0), 1'b1);
  endtask : test_index_select

  task automatic test_read_only();
    cfg(1'b1, 12'h20c, 4'hf, 32'hffff_ffff);
    cfg(1'b1, 12'h214, 4'hf, 32'hffff_ffff);
    cfg(1'b1, 12'h218, 4'hf, 32'hffff_ffff);
    check32({31'h0, o_cfg_rvalid}, 32'h0000_0000);
    rd(12'h20c, 32'h2201_0004, 1'b1);
    rd(12'h214, 32'h000b_8004, 1'b1);
    rd(12'h218, 32'h0000_0000, 1'b1);
    rd(12'h21c, 32'h0000_0000, 1'b0);
  endtask : test_read_only

  task automatic test_preload();
    load(power_budget_pkg::LOAD_BASE, 8'h5a);
    load(power_budget_pkg::LOAD_SCALE, 8'hff);
    load(power_budget_pkg::LOAD_LEVEL, 8'h02);
    load(power_budget_pkg::LOAD_ALLOC, 8'hff);
    rd(12'h214, word(3'h7, 8'h5a, 2'h3, 2'h2), 1'b1);
    rd(12'h218, 32'h0000_0001, 1'b1);
    cfg(1'b1, 12'h210, 4'h1, 32'h0000_0001);
    rd(12'h214, word(3'h1, 8'h5a, 2'h3, 2'h2), 1'b1);
    load(power_budget_pkg::LOAD_ALLOC, 8'h00);
    rd(12'h218, 32'h0000_0000, 1'b1);
  endtask : test_preload

  // preload and index write together, data read the next cycle
  task automatic test_preload_with_read();
    @(negedge i_clock);
    i_preload = '{valid: 1'b1, target: power_budget_pkg::LOAD_BASE,
      data: 8'h33};
    i_cfg_req = '{valid: 1'b1, write: 1'b1, addr: 12'h210, byte_en: 4'h1,
      wdata: 32'h0000_0000};
    @(negedge i_clock);
    i_preload.valid = 1'b0;
    i_cfg_req = '{valid: 1'b1, write: 1'b0, addr: 12'h214, byte_en: 4'h0,
      wdata: 32'h0000_0000};
    @(negedge i_clock);
    i_cfg_req.valid = 1'b0;
    check32({31'h0, o_cfg_rvalid}, 32'h0000_0001);
    check32(o_cfg_rdata, word(3'h7, 8'h33, 2'h3, 2'h2));
  endtask : test_preload_with_read

  // reset in mid-run brings preloaded fields back to defaults
  task automatic test_mid_reset();
    @(negedge i_clock);
    i_reset_n = 1'b0;
    repeat (2) @(negedge i_clock);
    i_reset_n = 1'b1;
    rd(12'h214, 32'h000b_8004, 1'b1);
    rd(12'h218, 32'h0000_0000, 1'b1);
    rd(12'h210, 32'h0000_0000, 1'b1);
  endtask : test_mid_reset

  // ==========================================================
  // main sequence
  initial begin
    n_errors = 0;
    samples_checked = 0;
    i_reset_n = 1'b0;
    i_upstream_port = 1'b1;
    i_cfg_req = '0;
    i_preload = '0;
    repeat (20) @(negedge i_clock);
    i_reset_n = 1'b1;
    test_reset_values();
    test_index_select();
    test_read_only();
    test_preload();
    test_preload_with_read();
    test_mid_reset();
    give_verdict();
  end
endmodule : power_budget_capability_tb_top
